/* test/tpu_regs_tb.sv */
// self-checking bench for the pattern register bank
`timescale 1ns/1ps
module tpu_regs_tb;
  import tpu_pkg::*;
  logic ref_clk, rst, hw_standby;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, go, done;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, dly;
  logic [2:0] cmp_match, chan;
  logic [15:0] pattern_output_pin, pattern_output_oe;
  int n_fail, samples_checked;

  // device under test
  tpu_regs u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .hw_standby(hw_standby),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cmp_match(cmp_match),
    .pattern_output_pin(pattern_output_pin),
    .pattern_output_oe(pattern_output_oe)
  );

  // timer side
  tpu_timer_model u_tmr (
    .ref_clk(ref_clk),
    .rst(rst),
    .go(go),
    .chan(chan),
    .dly(dly),
    .cmp_match(cmp_match),
    .done(done)
  );

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic stall;
    n_fail++;
    $display("unexpected at %0t: wait ran out %h %h", $time, 1'b0, 1'b1);
    wrap_up;
  endtask : stall

  // byte address is four times the register index
  function automatic logic [31:0] a4(input logic [19:0] i);
    a4 = {10'h000, i, 2'b00};
  endfunction : a4

  task automatic wr(input logic [31:0] a, input logic [7:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50 && !s_axi_bvalid)
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid)
      stall;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [7:0] e,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50 && !s_axi_rvalid)
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid)
      stall;
    chk(s_axi_rdata, {24'h0, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  // one match on channels c after d idle cycles, then let the copy land
  task automatic fire(input logic [2:0] c, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    go <= 1'b1;
    chan <= c;
    dly <= d;
    @(posedge ref_clk);
    go <= 1'b0;
    while (n < 40 && !done)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (!done)
      stall;
    @(posedge ref_clk);
  endtask : fire

  task automatic pins(input logic [15:0] e);
    chk({16'h0, pattern_output_pin}, {16'h0, e});
  endtask : pins

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    hw_standby = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, go} = '0;
    s_axi_wstrb = 4'hf;
    chan = 3'h0;
    dly = 4'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    // values after reset
    rd(a4(IDX_MODE), 8'hf0, RESP_OKAY);
    rd(a4(IDX_TSEL), 8'hff, RESP_OKAY);
    rd(a4(IDX_EN_LO), 8'h00, RESP_OKAY);
    rd(a4(IDX_EN_HI), 8'h00, RESP_OKAY);
    rd(a4(IDX_NXT_LO), 8'h00, RESP_OKAY);
    rd(a4(IDX_NXT_HI), 8'h00, RESP_OKAY);
    rd(a4(IDX_PORT_LO), 8'h00, RESP_OKAY);
    rd(a4(IDX_PORT_HI), 8'h00, RESP_OKAY);
    rd(a4(IDX_DIR_LO), 8'h00, RESP_OKAY);
    // software drives all pins as outputs; direction reads nothing back
    wr(a4(IDX_DIR_LO), 8'hff, RESP_OKAY);
    wr(a4(IDX_DIR_HI), 8'hff, RESP_OKAY);
    rd(a4(IDX_DIR_HI), 8'h00, RESP_OKAY);
    chk({16'h0, pattern_output_oe}, 32'h0000_ffff);
    // shared triggers: whole bytes, other addresses reserved
    wr(a4(IDX_NXT_LO), 8'ha5, RESP_OKAY);
    wr(a4(IDX_NXT_LO2), 8'h12, RESP_OKAY);
    rd(a4(IDX_NXT_LO), 8'ha5, RESP_OKAY);
    rd(a4(IDX_NXT_LO2), 8'hff, RESP_OKAY);
    wr(a4(IDX_NXT_HI), 8'h3c, RESP_OKAY);
    wr(a4(IDX_NXT_HI2), 8'h12, RESP_OKAY);
    rd(a4(IDX_NXT_HI), 8'h3c, RESP_OKAY);
    rd(a4(IDX_NXT_HI2), 8'hff, RESP_OKAY);
    // copy on channel 2 with only some low bits enabled
    wr(a4(IDX_EN_LO), 8'h0f, RESP_OKAY);
    wr(a4(IDX_EN_HI), 8'hff, RESP_OKAY);
    fire(3'b100, 4'h0);
    pins(16'h3c05);
    // enabled port bits ignore cpu writes
    wr(a4(IDX_PORT_LO), 8'hff, RESP_OKAY);
    wr(a4(IDX_PORT_HI), 8'h00, RESP_OKAY);
    rd(a4(IDX_PORT_LO), 8'hf5, RESP_OKAY);
    fire(3'b001, 4'h2);
    pins(16'h3cf5);
    // split triggers, codes 0,2,1,3 for groups 0..3
    wr(a4(IDX_TSEL), 8'hd8, RESP_OKAY);
    rd(a4(IDX_NXT_LO), 8'haf, RESP_OKAY);
    rd(a4(IDX_NXT_LO2), 8'hf5, RESP_OKAY);
    wr(a4(IDX_NXT_LO2), 8'h06, RESP_OKAY);
    wr(a4(IDX_NXT_LO), 8'h90, RESP_OKAY);
    rd(a4(IDX_NXT_LO2), 8'hf6, RESP_OKAY);
    rd(a4(IDX_NXT_LO), 8'h9f, RESP_OKAY);
    rd(a4(IDX_NXT_HI), 8'h3f, RESP_OKAY);
    rd(a4(IDX_NXT_HI2), 8'hfc, RESP_OKAY);
    wr(a4(IDX_NXT_HI2), 8'h01, RESP_OKAY);
    wr(a4(IDX_NXT_HI), 8'h70, RESP_OKAY);
    rd(a4(IDX_NXT_HI2), 8'hf1, RESP_OKAY);
    rd(a4(IDX_NXT_HI), 8'h7f, RESP_OKAY);
    wr(a4(IDX_EN_LO), 8'hff, RESP_OKAY);
    // each group moves only on its own channel
    fire(3'b001, 4'h3);
    pins(16'h3cf6);
    fire(3'b010, 4'h0);
    pins(16'h31f6);
    fire(3'b100, 4'h5);
    pins(16'h7196);
    // unmapped index and ignored upper address bits
    wr(a4(20'h0_0000), 8'h55, RESP_SLVERR);
    rd(a4(20'h0_0000), 8'h00, RESP_SLVERR);
    rd(32'hffc0_0000 | a4(IDX_EN_LO), 8'hff, RESP_OKAY);
    // mode keeps only its low nibble, upper bits read ones
    wr(a4(IDX_MODE), 8'h0a, RESP_OKAY);
    rd(a4(IDX_MODE), 8'hfa, RESP_OKAY);
    // hardware standby clears the bank
    @(posedge ref_clk);
    hw_standby <= 1'b1;
    repeat (2) @(posedge ref_clk);
    hw_standby <= 1'b0;
    @(posedge ref_clk);
    pins(16'h0000);
    chk({16'h0, pattern_output_oe}, 32'h0000_0000);
    rd(a4(IDX_NXT_LO), 8'h00, RESP_OKAY);
    rd(a4(IDX_NXT_HI), 8'h00, RESP_OKAY);
    rd(a4(IDX_TSEL), 8'hff, RESP_OKAY);
    rd(a4(IDX_MODE), 8'hf0, RESP_OKAY);
    rd(a4(IDX_EN_LO), 8'h00, RESP_OKAY);
    wrap_up;
  end
endmodule : tpu_regs_tb

/* test/tpu_timer_model.sv */
// compare match source standing in for the timer channels
`timescale 1ns/1ps
module tpu_timer_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request from the bench
  input wire logic go,
  input wire logic [2:0] chan,
  input wire logic [3:0] dly,
  // match pulses and completion
  output logic [2:0] cmp_match,
  output logic done
);
  logic busy_r;
  logic [3:0] cnt_r;
  logic [2:0] chan_r;

  // wait dly cycles, then one pulse; a timer match never stays high
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      chan_r <= 3'h0;
      cmp_match <= 3'h0;
      done <= 1'b0;
    end
    else
    begin
      cmp_match <= 3'h0;
      done <= 1'b0;
      if (go)
      begin
        busy_r <= 1'b1;
        cnt_r <= dly;
        chan_r <= chan;
      end
      else if (busy_r && cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      else if (busy_r)
      begin
        busy_r <= 1'b0;
        cmp_match <= chan_r;
        done <= 1'b1;
      end
    end
  end
endmodule : tpu_timer_model

/* verilog/tpu_group_copy.sv */
// one 4-bit pattern group: trigger pick and next-value merge
`timescale 1ns/1ps
module tpu_group_copy
  import tpu_pkg::*;
(
  // trigger selection
  input wire logic [1:0] sel,
  input wire logic [2:0] cmp_match,
  // group data
  input wire logic [3:0] en,
  input wire logic [3:0] nxt,
  input wire logic [3:0] cur,
  // result
  output logic fire,
  output logic [3:0] upd
);
  logic [1:0] chan;

  // each group picks its own timer channel
  assign chan = tpu_chan(sel);
  assign fire = cmp_match[chan];
  // disabled bits keep their value on a copy
  assign upd = (nxt & en) | (cur & ~en);
endmodule : tpu_group_copy

/* verilog/tpu_pkg.sv */
// constants shared by the timing pattern register bank
package tpu_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [19:0] IDX_DIR_LO = 20'h0_ee009;
  localparam logic [19:0] IDX_DIR_HI = 20'h0_ee00a;
  localparam logic [19:0] IDX_MODE = 20'h0_fffa0;
  localparam logic [19:0] IDX_TSEL = 20'h0_fffa1;
  localparam logic [19:0] IDX_EN_HI = 20'h0_fffa2;
  localparam logic [19:0] IDX_EN_LO = 20'h0_fffa3;
  localparam logic [19:0] IDX_NXT_HI = 20'h0_fffa4;
  localparam logic [19:0] IDX_NXT_LO = 20'h0_fffa5;
  localparam logic [19:0] IDX_NXT_HI2 = 20'h0_fffa6;
  localparam logic [19:0] IDX_NXT_LO2 = 20'h0_fffa7;
  localparam logic [19:0] IDX_PORT_LO = 20'h0_fffd9;
  localparam logic [19:0] IDX_PORT_HI = 20'h0_fffda;

  // values after reset
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_MODE = 8'hf0;
  localparam logic [7:0] RST_TSEL = 8'hff;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_NXT = 8'h00;
  localparam logic [7:0] RST_PORT = 8'h00;

  // reserved bits and write-only reads
  localparam logic [3:0] RSV_NIB = 4'hf;
  localparam logic [7:0] RSV_BYTE = 8'hff;
  localparam logic [7:0] WO_READ = 8'h00;
  localparam logic [3:0] MODE_RSV = 4'hf;

  // trigger select field positions, two bits per group
  localparam int TSEL_G0 = 0;
  localparam int TSEL_G1 = 2;
  localparam int TSEL_G2 = 4;
  localparam int TSEL_G3 = 6;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // bus address to register index, upper address bits ignored
  function automatic logic [19:0] tpu_index(input logic [31:0] addr);
    tpu_index = addr[21:2];
  endfunction : tpu_index

  // trigger field to timer channel; codes 2 and 3 both pick channel 2
  function automatic logic [1:0] tpu_chan(input logic [1:0] sel);
    tpu_chan = sel[1] ? 2'd2 : {1'b0, sel[0]};
  endfunction : tpu_chan
endpackage : tpu_pkg

/* verilog/tpu_regs.sv */
// timing pattern unit register bank with axi4-lite slave
`timescale 1ns/1ps
// Overview of operation
// - registers decode address bits 21 down to 2
// - direction registers write-only, reset zero
// - enabled low port bits ignore writes
// - enabled high port bits ignore writes
// - low group match copies next data
// - high group match copies next data
// - low next data cleared, standby too
// - high next data cleared, standby too
// - shared low trigger: full byte FA5
// - shared low trigger: FA7 reads ones
// - split low: group1 FA5, group0 FA7
// - split low: unused nibbles read ones
// - shared high trigger: full byte FA4
// - shared high trigger: FA6 reads ones
// - split high: group2 FA6, group3 FA4
// - split high: unused nibbles read ones
// - disabled bits never copied
// - each group selects own trigger
module tpu_regs
  import tpu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_standby,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer compare match pulses, channels 0 to 2
  input wire logic [2:0] cmp_match,
  // pattern pins
  output logic [15:0] pattern_output_pin,
  output logic [15:0] pattern_output_oe
);
  // register state
  logic [7:0] dir_lo_r;
  logic [7:0] dir_hi_r;
  logic [3:0] mode_r;
  logic [7:0] tsel_r;
  logic [7:0] en_lo_r;
  logic [7:0] en_hi_r;
  logic [7:0] nxt_lo_r;
  logic [7:0] nxt_hi_r;
  logic [7:0] port_lo_r;
  logic [7:0] port_hi_r;
  // bus state
  logic aw_have_r;
  logic w_have_r;
  logic [19:0] widx_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [7:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] rdata_nxt;
  logic rmap_nxt;
  logic wmap;
  // decode and group signals
  logic do_wr;
  logic wr_en;
  logic [19:0] ridx;
  logic shared_lo;
  logic shared_hi;
  logic [3:0] fire;
  logic [15:0] upd;
  logic [15:0] cur;
  logic [15:0] nxt_all;
  logic [15:0] en_all;

  // pins follow the port registers and direction bits
  assign pattern_output_pin = {port_hi_r, port_lo_r};
  assign pattern_output_oe = {dir_hi_r, dir_lo_r};

  // paired groups share when they pick the same channel
  assign shared_lo = tpu_chan(tsel_r[TSEL_G0+:2]) ==
                     tpu_chan(tsel_r[TSEL_G1+:2]);
  assign shared_hi = tpu_chan(tsel_r[TSEL_G2+:2]) ==
                     tpu_chan(tsel_r[TSEL_G3+:2]);

  // per-group trigger and merge
  assign cur = {port_hi_r, port_lo_r};
  assign nxt_all = {nxt_hi_r, nxt_lo_r};
  assign en_all = {en_hi_r, en_lo_r};
  for (genvar g = 0; g < 4; g++)
  begin : g_grp
    tpu_group_copy u_copy (
      .sel(tsel_r[2*g+:2]),
      .cmp_match(cmp_match),
      .en(en_all[4*g+:4]),
      .nxt(nxt_all[4*g+:4]),
      .cur(cur[4*g+:4]),
      .fire(fire[g]),
      .upd(upd[4*g+:4])
    );
  end

  // handshake outputs; one write and one read at a time
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = {24'h00_0000, rdata_r};
  assign s_axi_rresp = rresp_r;
  assign do_wr = aw_have_r && w_have_r && !bvalid_r;
  assign wr_en = do_wr && wstrb_r; // only the low byte lane holds data
  assign ridx = tpu_index(s_axi_araddr);

  // which write indices are mapped
  always_comb
  begin
    unique case (widx_r)
      IDX_DIR_LO, IDX_DIR_HI, IDX_MODE, IDX_TSEL, IDX_EN_HI,
      IDX_EN_LO, IDX_NXT_HI, IDX_NXT_LO, IDX_NXT_HI2, IDX_NXT_LO2,
      IDX_PORT_LO, IDX_PORT_HI: wmap = 1'b1;
      default: wmap = 1'b0;
    endcase
  end

  // capture write address and data in either order
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      widx_r <= '0;
      wdata_r <= '0;
      wstrb_r <= 1'b0;
    end
    else if (do_wr)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        widx_r <= tpu_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb_r <= s_axi_wstrb[0];
      end
    end
  end

  // write response raised on the same edge the write is applied
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wmap ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // direction, mode, trigger select and enables
  always_ff @(posedge ref_clk)
  begin
    if (rst || hw_standby)
    begin
      dir_lo_r <= RST_DIR;
      dir_hi_r <= RST_DIR;
      mode_r <= RST_MODE[3:0];
      tsel_r <= RST_TSEL;
      en_lo_r <= RST_EN;
      en_hi_r <= RST_EN;
    end
    else if (wr_en)
    begin
      unique case (widx_r)
        IDX_DIR_LO: dir_lo_r <= wdata_r;
        IDX_DIR_HI: dir_hi_r <= wdata_r;
        IDX_MODE: mode_r <= wdata_r[3:0];
        IDX_TSEL: tsel_r <= wdata_r;
        IDX_EN_LO: en_lo_r <= wdata_r;
        IDX_EN_HI: en_hi_r <= wdata_r;
        default: ;
      endcase
    end
  end

  // next data; the bus layout depends on trigger sharing
  always_ff @(posedge ref_clk)
  begin
    if (rst || hw_standby)
    begin
      nxt_lo_r <= RST_NXT;
      nxt_hi_r <= RST_NXT;
    end
    else if (wr_en)
    begin
      unique case (widx_r)
        IDX_NXT_LO:
          if (shared_lo)
            nxt_lo_r <= wdata_r;
          else
            nxt_lo_r[7:4] <= wdata_r[7:4];
        IDX_NXT_LO2:
          if (!shared_lo)
            nxt_lo_r[3:0] <= wdata_r[3:0];
        IDX_NXT_HI:
          if (shared_hi)
            nxt_hi_r <= wdata_r;
          else
            nxt_hi_r[7:4] <= wdata_r[7:4];
        IDX_NXT_HI2:
          if (!shared_hi)
            nxt_hi_r[3:0] <= wdata_r[3:0];
        default: ;
      endcase
    end
  end

  // port data: cpu owns disabled bits, the copy owns enabled ones,
  // so the two never contend for one bit in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst || hw_standby)
    begin
      port_lo_r <= RST_PORT;
      port_hi_r <= RST_PORT;
    end
    else
    begin
      for (int g = 0; g < 2; g++)
      begin
        if (fire[g])
          port_lo_r[4*g+:4] <= upd[4*g+:4];
        if (fire[g+2])
          port_hi_r[4*g+:4] <= upd[4*g+8+:4];
      end
      if (wr_en && widx_r == IDX_PORT_LO)
      begin
        for (int b = 0; b < 8; b++)
          if (!en_lo_r[b])
            port_lo_r[b] <= wdata_r[b];
      end
      if (wr_en && widx_r == IDX_PORT_HI)
      begin
        for (int b = 0; b < 8; b++)
          if (!en_hi_r[b])
            port_hi_r[b] <= wdata_r[b];
      end
    end
  end

  // read data mux; reserved bits read as ones
  always_comb
  begin
    rmap_nxt = 1'b1;
    rdata_nxt = WO_READ;
    unique case (ridx)
      IDX_DIR_LO, IDX_DIR_HI: rdata_nxt = WO_READ;
      IDX_MODE: rdata_nxt = {MODE_RSV, mode_r};
      IDX_TSEL: rdata_nxt = tsel_r;
      IDX_EN_HI: rdata_nxt = en_hi_r;
      IDX_EN_LO: rdata_nxt = en_lo_r;
      IDX_NXT_LO: rdata_nxt = shared_lo ? nxt_lo_r
                              : {nxt_lo_r[7:4], RSV_NIB};
      IDX_NXT_LO2: rdata_nxt = shared_lo ? RSV_BYTE
                               : {RSV_NIB, nxt_lo_r[3:0]};
      IDX_NXT_HI: rdata_nxt = shared_hi ? nxt_hi_r
                              : {nxt_hi_r[7:4], RSV_NIB};
      IDX_NXT_HI2: rdata_nxt = shared_hi ? RSV_BYTE
                               : {RSV_NIB, nxt_hi_r[3:0]};
      IDX_PORT_LO: rdata_nxt = port_lo_r;
      IDX_PORT_HI: rdata_nxt = port_hi_r;
      default: rmap_nxt = 1'b0;
    endcase
  end

  // read channel: data registered on the same edge the address is taken
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= rmap_nxt ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic wr_lo;
  logic wr_hi;
  assign wr_lo = wr_en && widx_r == IDX_PORT_LO;
  assign wr_hi = wr_en && widx_r == IDX_PORT_HI;

  chk_dir_reset: assert property (
    $fell(rst) |-> dir_lo_r == RST_DIR && dir_hi_r == RST_DIR)
    else $error("direction not cleared after reset");
  chk_lo_guard: assert property (
    wr_lo && !fire[0] && !fire[1] |=>
      ((port_lo_r ^ $past(port_lo_r)) & $past(en_lo_r)) == 8'h00)
    else $error("enabled low port bit written by cpu");
  chk_hi_guard: assert property (
    wr_hi && !fire[2] && !fire[3] |=>
      ((port_hi_r ^ $past(port_hi_r)) & $past(en_hi_r)) == 8'h00)
    else $error("enabled high port bit written by cpu");
  chk_lo_copy: assert property (
    fire[0] |=> (port_lo_r[3:0] & $past(en_lo_r[3:0])) ==
      ($past(nxt_lo_r[3:0]) & $past(en_lo_r[3:0])))
    else $error("group 0 copy wrong");
  chk_hi_copy: assert property (
    fire[3] |=> (port_hi_r[7:4] & $past(en_hi_r[7:4])) ==
      ($past(nxt_hi_r[7:4]) & $past(en_hi_r[7:4])))
    else $error("group 3 copy wrong");
  chk_stby_clear: assert property (
    hw_standby |=> nxt_lo_r == RST_NXT && nxt_hi_r == RST_NXT)
    else $error("next data kept through hardware standby");
  chk_shared_rsv: assert property (
    s_axi_arvalid && s_axi_arready && ridx == IDX_NXT_LO2 &&
      shared_lo |=> s_axi_rdata[7:0] == RSV_BYTE)
    else $error("reserved byte did not read ones");
  chk_split_rsv: assert property (
    wr_en && widx_r == IDX_NXT_LO && !shared_lo |=>
      nxt_lo_r[3:0] == $past(nxt_lo_r[3:0]))
    else $error("reserved nibble took a write");
  // standby clears the whole port, so it is not a copy fault
  chk_disabled_hold: assert property (
    fire[1] && !wr_lo && !hw_standby |=>
      ((port_lo_r[7:4] ^ $past(port_lo_r[7:4])) &
       ~$past(en_lo_r[7:4])) == 4'h0)
    else $error("disabled bit changed on copy");
  chk_idle_group: assert property (
    !fire[2] && !wr_hi && !hw_standby |=>
      port_hi_r[3:0] == $past(port_hi_r[3:0]))
    else $error("untriggered group changed");
  chk_b_follow: assert property (
    do_wr |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write response missing");

  cov_copy_lo: cover property (fire[0] && en_lo_r[0]);
  cov_split_wr: cover property (
    wr_en && widx_r == IDX_NXT_HI2 && !shared_hi);
  cov_guard_wr: cover property (wr_lo && en_lo_r != 8'h00);
endmodule : tpu_regs
